// ### rtl/swm_pkg.sv
package swm_pkg;

	// ------------------------------------------------------------------
	// Geometry of the serial word and of the switch inputs
	// ------------------------------------------------------------------
	localparam int WORD_W = 24;
	localparam int NUM_PROG = 8;
	localparam int NUM_GND = 14;
	localparam int NUM_SW = NUM_PROG + NUM_GND;
	localparam logic [4:0] LAST_BIT = 5'h17;

	// ------------------------------------------------------------------
	// Command codes carried in bits 23..16 of the command word
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_SETTINGS = 8'h01;
	localparam logic [7:0] CMD_WAKE_PROG = 8'h02;
	localparam logic [7:0] CMD_WAKE_GND = 8'h03;
	localparam logic [7:0] CMD_METAL_PROG = 8'h04;
	localparam logic [7:0] CMD_METAL_GND = 8'h05;
	localparam logic [7:0] CMD_TIMER_PROG = 8'h07;
	localparam logic [7:0] CMD_TIMER_GND = 8'h08;
	localparam logic [7:0] CMD_TRI_PROG = 8'h09;
	localparam logic [7:0] CMD_TRI_GND = 8'h0a;
	localparam logic [7:0] CMD_ANALOG = 8'h0b;
	localparam logic [7:0] CMD_CALIB = 8'h0c;
	localparam logic [7:0] CMD_RESET = 8'h0d;

	// ------------------------------------------------------------------
	// Reset values and status word field positions
	// ------------------------------------------------------------------
	localparam logic [NUM_PROG-1:0] POLARITY_RST = 8'hff;
	localparam logic [NUM_SW-1:0] WAKE_EN_RST = 22'h3fffff;
	localparam int STAT_THERM_BIT = 23;
	localparam int STAT_INT_BIT = 22;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic {
		MODE_NORMAL = 1'b0,
		MODE_SLEEP = 1'b1
	} swm_mode_t;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_SHIFT = 2'b01,
		FR_APPLY = 2'b11
	} swm_frame_t;

	typedef enum logic [3:0] {
		CK_NONE = 4'h0,
		CK_POLARITY = 4'h1,
		CK_WAKE_INT = 4'h2,
		CK_WETTING = 4'h3,
		CK_WET_TIMER = 4'h4,
		CK_TRISTATE = 4'h5,
		CK_ANALOG = 4'h6,
		CK_CALIB = 4'h7,
		CK_RESET = 4'h8
	} swm_cmd_kind_t;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] mid;
		logic [7:0] low;
	} swm_cmd_word_t;

	typedef struct packed {
		logic therm;
		logic int_flag;
		logic [NUM_PROG-1:0] prog;
		logic [NUM_GND-1:0] gnd;
	} swm_status_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic si;
		logic wake;
		logic int_line;
		logic vdd;
		logic therm;
		logic [NUM_PROG-1:0] prog_above;
		logic [NUM_GND-1:0] gnd_above;
	} swm_pins_t;

	typedef struct packed {
		swm_mode_t mode;
		swm_frame_t frame;
		logic cs_act;
		logic sclk;
		logic wake;
		logic int_line;
		logic [WORD_W-1:0] shift;
		logic so;
		logic [4:0] bit_cnt;
		logic full;
		logic int_pend;
		logic chg_in_frame;
		logic int_pin_cap;
		logic [NUM_PROG-1:0] polarity;
		logic [NUM_SW-1:0] wake_en;
		logic [NUM_SW-1:0] closed;
		logic closed_valid;
		logic cmd_valid;
		swm_cmd_kind_t cmd_kind;
		swm_cmd_word_t cmd_word;
		logic defaults_load;
	} swm_state_t;

endpackage

// ### rtl/swm_spi_ctrl.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Switch monitor serial control
// ----------------------------------------------------------------------
// Contract
// - Enabled switch change pulls interrupt low.
// - Chip select fall latches interrupt pin, flag.
// - Chip select rise releases interrupt unless changed.
// - Only interrupting device reports its flag.
// - Wake driven low Normal, released Sleep.
// - Wake fall needs interrupt high with supply.
// - Listed events bring Sleep back to Normal.
// - Programmable input polarity sets closed meaning.
// - Ground inputs: below reference means closed.
// - Every response carries status, interrupt, thermal.
// - Switch states sampled at chip select fall.
// - One transfer is twenty-four serial clocks.
// - Logic supply loss never changes mode.
// - Without logic supply, serial link ignored.
// - Reset gives Normal mode and defaults.
// - Writes only in Normal with supply.
// - Eight command types are decoded.
// - Code 01 loads eight polarity bits.
// - Closed input reads one regardless polarity.
// - Sample input falling, drive output rising, MSB first.
// - Act on command at chip select rise.
// - Chip select high: ignore clock, release output.
module swm_spi_ctrl
	import swm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Serial link from the host
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	output logic so,
	output logic so_oe,
	// Open-drain interrupt line
	input wire logic int_line_in,
	output logic int_out,
	output logic int_oe,
	// Open-drain wake pin
	input wire logic wake_in,
	output logic wake_out,
	output logic wake_oe,
	// Supply and front end
	input wire logic logic_supply_ok,
	input wire logic thermal_flag,
	input wire logic [NUM_PROG-1:0] programmable_inputs_above_ref,
	input wire logic [NUM_GND-1:0] ground_only_inputs_above_ref,
	// Same-clock events from neighbouring logic
	input wire logic interrupt_timer_expired,
	input wire logic sleep_request,
	// Towards the wetting, tri-state, analog and timer blocks
	output logic in_normal,
	output logic [NUM_PROG-1:0] polarity_bits,
	output logic [NUM_SW-1:0] wake_int_enable,
	output logic cmd_valid,
	output swm_cmd_kind_t cmd_kind,
	output swm_cmd_word_t cmd_word,
	output logic defaults_load,
	output logic int_pin_latched
);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Map a command code onto its command type.
	function automatic swm_cmd_kind_t decode_cmd(input logic [7:0] code);
		swm_cmd_kind_t k;
		case (code)
			CMD_SETTINGS: k = CK_POLARITY;
			CMD_WAKE_PROG, CMD_WAKE_GND: k = CK_WAKE_INT;
			CMD_METAL_PROG, CMD_METAL_GND: k = CK_WETTING;
			CMD_TIMER_PROG, CMD_TIMER_GND: k = CK_WET_TIMER;
			CMD_TRI_PROG, CMD_TRI_GND: k = CK_TRISTATE;
			CMD_ANALOG: k = CK_ANALOG;
			CMD_CALIB: k = CK_CALIB;
			CMD_RESET: k = CK_RESET;
			default: k = CK_NONE;
		endcase
		return k;
	endfunction

	// Turn comparator results into closed flags, one meaning closed.
	function automatic logic [NUM_SW-1:0] closed_map(
		input logic [NUM_PROG-1:0] pol,
		input logic [NUM_PROG-1:0] p_above,
		input logic [NUM_GND-1:0] g_above
	);
		logic [NUM_PROG-1:0] p_closed;
		p_closed = ~(p_above ^ pol);
		return {p_closed, ~g_above};
	endfunction

	// ------------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------------
	swm_pins_t pins_raw;
	swm_pins_t pins_s;

	assign pins_raw = '{
		cs_n: cs_n,
		sclk: sclk,
		si: si,
		wake: wake_in,
		int_line: int_line_in,
		vdd: logic_supply_ok,
		therm: thermal_flag,
		prog_above: programmable_inputs_above_ref,
		gnd_above: ground_only_inputs_above_ref
	};

	// Every pin level crosses two flops before any decision is made.
	swm_sync #(
		.W($bits(swm_pins_t))
	) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	swm_state_t st_q;
	swm_state_t st_d;

	// Derived terms used by the next-state process.
	logic cs_act;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic wake_fall;
	logic int_fall;
	logic [NUM_SW-1:0] closed_now;
	logic [NUM_SW-1:0] sw_change;
	logic any_change;
	logic wake_event;
	logic int_clear;
	swm_status_t status_now;
	swm_cmd_word_t rx_word;
	swm_cmd_kind_t rx_kind;

	// A missing logic supply makes chip select look idle, so the link and
	// its wake source both go quiet. The mode itself is left alone.
	assign cs_act = pins_s.vdd & ~pins_s.cs_n;
	assign cs_fall = cs_act & ~st_q.cs_act;
	assign cs_rise = ~cs_act & st_q.cs_act;

	// Serial clock edges count only inside an open frame.
	assign sclk_rise = (st_q.frame == FR_SHIFT) & cs_act & pins_s.sclk & ~st_q.sclk;
	assign sclk_fall = (st_q.frame == FR_SHIFT) & cs_act & ~pins_s.sclk & st_q.sclk;

	assign wake_fall = ~pins_s.wake & st_q.wake;
	assign int_fall = ~pins_s.int_line & st_q.int_line;

	// Switch change detection against the last sampled state.
	assign closed_now = closed_map(st_q.polarity, pins_s.prog_above, pins_s.gnd_above);
	assign sw_change = (closed_now ^ st_q.closed) & st_q.wake_en & {NUM_SW{st_q.closed_valid}};
	assign any_change = |sw_change;

	// Sleep exit sources. The wake pin needs the interrupt line high only
	// while the logic supply is there; otherwise the line is meaningless.
	assign wake_event = any_change | interrupt_timer_expired
		| (wake_fall & (~pins_s.vdd | pins_s.int_line))
		| (int_fall & pins_s.vdd & pins_s.wake)
		| cs_fall;

	// The response word is rebuilt from live inputs on every frame start.
	assign status_now = '{
		therm: pins_s.therm,
		int_flag: st_q.int_pend,
		prog: closed_now[NUM_SW-1:NUM_GND],
		gnd: closed_now[NUM_GND-1:0]
	};

	assign rx_word = st_q.shift;
	assign rx_kind = decode_cmd(rx_word.code);

	// The interrupt clears at frame end only if no change arrived meanwhile.
	assign int_clear = cs_rise & ~st_q.chg_in_frame & ~any_change;

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.cs_act = cs_act;
		st_d.sclk = pins_s.sclk;
		st_d.wake = pins_s.wake;
		st_d.int_line = pins_s.int_line;
		st_d.closed = closed_now;
		st_d.closed_valid = 1'b1;
		st_d.cmd_valid = 1'b0;
		st_d.defaults_load = 1'b0;

		// Interrupt flag: a change seen in the same cycle as the clear
		// wins, so no switch event can slip past the host.
		if (int_clear) begin
			st_d.int_pend = 1'b0;
		end
		if (any_change) begin
			st_d.int_pend = 1'b1;
		end

		// Mode handling. Supply loss is not an input here on purpose.
		case (st_q.mode)
			MODE_NORMAL: begin
				if (sleep_request && st_q.frame == FR_IDLE && !cs_act) begin
					st_d.mode = MODE_SLEEP;
				end
			end
			MODE_SLEEP: begin
				if (wake_event) begin
					st_d.mode = MODE_NORMAL;
				end
			end
			default: begin
				st_d.mode = MODE_NORMAL;
			end
		endcase

		// Serial frame handling.
		case (st_q.frame)
			FR_IDLE: begin
				if (cs_fall) begin
					st_d.frame = FR_SHIFT;
					st_d.shift = status_now;
					st_d.so = status_now[STAT_THERM_BIT];
					st_d.int_pin_cap = pins_s.int_line;
					st_d.bit_cnt = '0;
					st_d.full = 1'b0;
					st_d.chg_in_frame = 1'b0;
				end
			end
			FR_SHIFT: begin
				if (any_change) begin
					st_d.chg_in_frame = 1'b1;
				end
				if (sclk_rise) begin
					st_d.so = st_q.shift[WORD_W-1];
				end
				if (sclk_fall) begin
					st_d.shift = {st_q.shift[WORD_W-2:0], pins_s.si};
					if (st_q.bit_cnt == LAST_BIT) begin
						st_d.bit_cnt = '0;
						st_d.full = 1'b1;
					end else begin
						st_d.bit_cnt = st_q.bit_cnt + 5'h01;
					end
				end
				if (cs_rise) begin
					// Only a whole number of words counts; in a daisy chain the
					// last word left in the register is ours.
					if (st_q.full && st_q.bit_cnt == '0 && st_q.mode == MODE_NORMAL) begin
						st_d.frame = FR_APPLY;
					end else begin
						st_d.frame = FR_IDLE;
					end
				end
			end
			FR_APPLY: begin
				// The command takes effect one cycle after chip select rises.
				st_d.frame = FR_IDLE;
				st_d.cmd_valid = (rx_kind != CK_NONE);
				st_d.cmd_kind = rx_kind;
				st_d.cmd_word = rx_word;
				case (rx_kind)
					CK_POLARITY: begin
						st_d.polarity = rx_word.low;
					end
					CK_WAKE_INT: begin
						if (rx_word.code == CMD_WAKE_PROG) begin
							st_d.wake_en[NUM_SW-1:NUM_GND] = rx_word.low;
						end else begin
							st_d.wake_en[NUM_GND-1:0] = {rx_word.mid[5:0], rx_word.low};
						end
					end
					CK_RESET: begin
						st_d.polarity = POLARITY_RST;
						st_d.wake_en = WAKE_EN_RST;
						st_d.defaults_load = 1'b1;
						st_d.mode = MODE_NORMAL;
						st_d.closed_valid = 1'b0;
					end
					default: begin
						st_d.polarity = st_q.polarity;
					end
				endcase
			end
			default: begin
				st_d.frame = FR_IDLE;
			end
		endcase

		// A frame cut short by supply loss falls back to idle.
		if (!pins_s.vdd && st_q.frame == FR_SHIFT) begin
			st_d.frame = FR_IDLE;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Battery power-on and the reset command land in the same defaults.
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_q.mode <= MODE_NORMAL;
			st_q.frame <= FR_IDLE;
			st_q.cs_act <= 1'b0;
			st_q.sclk <= 1'b0;
			st_q.wake <= 1'b0;
			st_q.int_line <= 1'b1;
			st_q.shift <= '0;
			st_q.so <= 1'b0;
			st_q.bit_cnt <= '0;
			st_q.full <= 1'b0;
			st_q.int_pend <= 1'b0;
			st_q.chg_in_frame <= 1'b0;
			st_q.int_pin_cap <= 1'b1;
			st_q.polarity <= POLARITY_RST;
			st_q.wake_en <= WAKE_EN_RST;
			st_q.closed <= '0;
			st_q.closed_valid <= 1'b0;
			st_q.cmd_valid <= 1'b0;
			st_q.cmd_kind <= CK_NONE;
			st_q.cmd_word <= '0;
			st_q.defaults_load <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// Serial output is driven only while a frame is open.
	assign so = st_q.so;
	assign so_oe = (st_q.frame == FR_SHIFT) & cs_act;

	// Open drain: the line is pulled low only while our flag is pending,
	// so a neighbour on a shared line sees our flag as a low line.
	assign int_out = 1'b0;
	assign int_oe = st_q.int_pend;

	// The wake pin doubles as a supply enable, held low in Normal.
	assign wake_out = 1'b0;
	assign wake_oe = (st_q.mode == MODE_NORMAL);

	// Configuration and command strobe for the neighbouring blocks.
	assign in_normal = (st_q.mode == MODE_NORMAL);
	assign polarity_bits = st_q.polarity;
	assign wake_int_enable = st_q.wake_en;
	assign cmd_valid = st_q.cmd_valid;
	assign cmd_kind = st_q.cmd_kind;
	assign cmd_word = st_q.cmd_word;
	assign defaults_load = st_q.defaults_load;
	assign int_pin_latched = st_q.int_pin_cap;

	// Limitation: with a 20 MHz core clock and two-flop sampling the host
	// clock must stay well below the 6 MHz ceiling it is allowed.

endmodule

// ### rtl/swm_sync.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Two-stage synchroniser for a bundle of asynchronous levels
// ----------------------------------------------------------------------
module swm_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// The first stage feeds only the second; nothing else may look at it.
	// The chain keeps sampling through reset, so the levels seen at release
	// are the real pins and no false edge or switch change follows reset.
	// The reset input is kept only so every block has the same port list.
	always_ff @(posedge core_clk) begin
		meta_q <= async_in;
		sync_q <= meta_q;
	end

	assign sync_out = sync_q;

endmodule

// ### sim/swm_host_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host serial master with a 400 ns serial clock
// ------------------------------------------------------------
module swm_host_model (
	// Clock
	input wire logic core_clk,
	// Serial link
	output logic cs_n,
	output logic sclk,
	output logic si,
	input wire logic so
);
	// Idle deselected with the clock parked low.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	// Data is set at the clock rise and read at the fall, once the output settled.
	task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
		rx = '0;
		@(posedge core_clk) cs_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge core_clk) sclk <= 1'b1;
			si <= tx[i];
			repeat (3) @(posedge core_clk);
			@(posedge core_clk) rx = {rx[46:0], so};
			sclk <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
		@(posedge core_clk) cs_n <= 1'b1;
		si <= ~si; // A released line never keeps showing its last bit.
		repeat (12) @(posedge core_clk);
	endtask
endmodule

// ### sim/swm_spi_ctrl_bench.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Self-checking bench for the serial control block
// ------------------------------------------------------------
module swm_spi_ctrl_bench
	import swm_pkg::*;
;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic tmr = 1'b0, slp = 1'b0, ext_int = 1'b0, ext_wake = 1'b0, th = 1'b0, sup = 1'b1;
	logic cs_n, sclk, si, so, so_oe, int_out, int_oe, wake_out, wake_oe;
	logic in_normal, cmd_valid, defaults_load, int_pin_latched, pend, chg, p0, dl_seen;
	logic [NUM_PROG-1:0] pa = '0, polarity_bits, pol = POLARITY_RST;
	logic [NUM_GND-1:0] ga = '0;
	logic [NUM_SW-1:0] wake_int_enable, en = WAKE_EN_RST, closed;
	swm_cmd_kind_t cmd_kind, last_kind;
	swm_cmd_word_t cmd_word;
	logic [47:0] rx;
	logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09,
		8'h0a, 8'h0b, 8'h0c};
	int n_fail = 0;
	int compares = 0;

	always #25 core_clk = ~core_clk;

	swm_spi_ctrl dut (
		.core_clk, .reset_n, .cs_n, .sclk, .si, .so, .so_oe,
		.int_line_in(~(int_oe | ext_int)), .int_out, .int_oe,
		.wake_in(~(wake_oe | ext_wake)), .wake_out, .wake_oe,
		.logic_supply_ok(sup), .thermal_flag(th),
		.programmable_inputs_above_ref(pa), .ground_only_inputs_above_ref(ga),
		.interrupt_timer_expired(tmr), .sleep_request(slp),
		.in_normal, .polarity_bits, .wake_int_enable, .cmd_valid, .cmd_kind, .cmd_word,
		.defaults_load, .int_pin_latched
	);
	swm_host_model host (.core_clk, .cs_n, .sclk, .si, .so);

	// The command pulse lasts one cycle, so its kind is kept for later checks.
	always @(posedge core_clk) begin
		if (cmd_valid === 1'b1) last_kind <= cmd_kind;
		if (defaults_load === 1'b1) dl_seen <= 1'b1;
	end

	task automatic cmp(input string what, input logic [47:0] e, input logic [47:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	function automatic swm_cmd_kind_t kind(input logic [7:0] c);
		case (c)
			CMD_SETTINGS: return CK_POLARITY;
			CMD_WAKE_PROG, CMD_WAKE_GND: return CK_WAKE_INT;
			CMD_METAL_PROG, CMD_METAL_GND: return CK_WETTING;
			CMD_TIMER_PROG, CMD_TIMER_GND: return CK_WET_TIMER;
			CMD_TRI_PROG, CMD_TRI_GND: return CK_TRISTATE;
			CMD_ANALOG: return CK_ANALOG;
			CMD_CALIB: return CK_CALIB;
			default: return CK_RESET;
		endcase
	endfunction

	// Closed image of all inputs; an enabled change raises the flag, in Sleep too.
	task automatic upd();
		logic [NUM_SW-1:0] nc;
		nc = {~(pol ^ pa), ~ga};
		if (|((nc ^ closed) & en)) begin
			pend = 1'b1;
			chg = 1'b1;
		end
		closed = nc;
	endtask

	task automatic stim();
		@(posedge core_clk) pa <= NUM_PROG'($urandom);
		ga <= NUM_GND'($urandom);
		th <= 1'($urandom);
		#1 upd();
		repeat (6) @(posedge core_clk);
		#1 cmp("int_oe", pend, int_oe);
	endtask

	// One frame: status is what stood at select fall; the last 24 bits act at rise.
	task automatic txn(input int n, input logic [47:0] w, input logic chk);
		logic [47:0] e;
		logic [7:0] c;
		c = w[23:16];
		p0 = pend;
		chg = 1'b0;
		dl_seen = 1'b0;
		e = (n == 48) ? {th, pend, closed, w[47:24]} : {24'h0, th, pend, closed};
		host.xfer(n, w, rx);
		if (chk) cmp("status", e, rx);
		if (chk) cmp("int_pin_latched", !p0, int_pin_latched);
		if (sup) begin
			pend = chg;
			if (c == CMD_SETTINGS) pol = w[7:0];
			if (c == CMD_WAKE_PROG) en[21:14] = w[7:0];
			if (c == CMD_WAKE_GND) en[13:0] = w[13:0];
			if (c == CMD_RESET) en = WAKE_EN_RST;
			if (c == CMD_RESET) pol = POLARITY_RST;
		end
		upd();
		#1 cmp("polarity_bits", pol, polarity_bits);
		cmp("wake_int_enable", en, wake_int_enable);
		if (c != 8'h00 && sup) cmp("cmd_kind", kind(c), last_kind);
		if (c != CMD_RESET) cmp("int_oe", pend, int_oe);
		if (sup) cmp("cmd_word", w[23:0], cmd_word);
		cmp("defaults_load", (c == CMD_RESET) && sup, dl_seen);
	endtask

	// Sleep, offer one wake source, then see whether the part woke.
	task automatic nap(input int e, input logic exp);
		@(posedge core_clk) ext_int <= (e >= 5);
		sup <= (e < 6);
		slp <= 1'b1;
		@(posedge core_clk) slp <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1 cmp("sleep", 2'b00, {in_normal, wake_oe});
		@(posedge core_clk);
		case (e)
			0: tmr <= 1'b1;
			2: ext_int <= 1'b1;
			3, 6: txn(24, 48'h0, 1'b0);
			4: pa <= ~pa;
			default: ext_wake <= 1'b1;
		endcase
		#1 upd();
		@(posedge core_clk) tmr <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1 cmp("in_normal", exp, in_normal);
		@(posedge core_clk) ext_wake <= 1'b0;
		ext_int <= 1'b0;
		sup <= 1'b1;
		tmr <= !exp; // Parts left asleep come back through the timer.
		@(posedge core_clk) tmr <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1 cmp("wake", 2'b11, {in_normal, wake_oe});
	endtask

	// Main sequence.
	initial begin
		void'($urandom(32'h5d94));
		pend = 1'b0;
		// Ground inputs start at random levels, so a start-up interrupt would show.
		@(posedge core_clk) ga <= NUM_GND'($urandom);
		#1 closed = {~(pol ^ pa), ~ga};
		repeat (11) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 cmp("polarity_bits", POLARITY_RST, polarity_bits);
		cmp("wake_int_enable", WAKE_EN_RST, wake_int_enable);
		cmp("mode", 6'b110000, {in_normal, wake_oe, so_oe, defaults_load, int_out, wake_out});
		cmp("int_oe", 1'b0, int_oe);
		foreach (codes[i]) begin
			stim();
			txn(24, {24'h0, codes[i], 8'($urandom), 8'($urandom)}, 1'b1);
		end
		txn(24, {24'h0, CMD_WAKE_PROG, 16'h00ff}, 1'b1);
		// A change while selected keeps the line asserted after release.
		fork
			txn(24, 48'h0, 1'b1);
			begin
				repeat (100) @(posedge core_clk);
				pa <= ~pa;
				#1 upd();
			end
		join
		txn(48, {24'($urandom), CMD_SETTINGS, 16'h005a}, 1'b1);
		@(posedge core_clk) sup <= 1'b0;
		repeat (4) @(posedge core_clk);
		txn(24, {24'h0, CMD_SETTINGS, 8'h00, ~pol}, 1'b0);
		cmp("in_normal", 1'b1, in_normal);
		@(posedge core_clk) sup <= 1'b1;
		repeat (4) @(posedge core_clk);
		txn(24, {24'h0, CMD_SETTINGS, 16'h00ff}, 1'b1);
		txn(24, {24'h0, CMD_RESET, 16'h0000}, 1'b1);
		txn(24, 48'h0, 1'b1);
		for (int e = 0; e < 8; e++) begin
			nap(e, !(e == 5 || e == 6));
		end
		txn(24, 48'h0, 1'b1);
		summarize();
	end

	// Cut a hang short; the whole run needs well under a third of this span.
	initial begin
		repeat (60000) @(posedge core_clk);
		n_fail++;
		summarize();
	end
endmodule

// ### sim/swm_spi_ctrl_monitor.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Port checker for the serial control block
// ------------------------------------------------------------
module swm_spi_ctrl_monitor
	import swm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Link and pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic so,
	input wire logic so_oe,
	input wire logic int_oe,
	input wire logic wake_oe,
	// Mode and commands
	input wire logic logic_supply_ok,
	input wire logic sleep_request,
	input wire logic in_normal,
	input wire logic [NUM_PROG-1:0] polarity_bits,
	input wire logic cmd_valid,
	input wire swm_cmd_kind_t cmd_kind,
	input wire swm_cmd_word_t cmd_word
);
	// Everything here lives in the core clock domain.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	property p_so_idle; cs_n [*4] |-> !so_oe; endproperty
	a_so_idle: assert property (p_so_idle) else $error("so driven while deselected");
	property p_wake; wake_oe == in_normal; endproperty
	a_wake: assert property (p_wake) else $error("wake pin does not follow mode");
	property p_supply; in_normal && !logic_supply_ok && !sleep_request |=> in_normal; endproperty
	a_supply: assert property (p_supply) else $error("mode left on supply loss");
	property p_pol; cmd_valid && cmd_kind == CK_POLARITY |-> polarity_bits == cmd_word.low; endproperty
	a_pol: assert property (p_pol) else $error("polarity not loaded from low byte");
	property p_kind; cmd_valid |-> (cmd_kind == CK_POLARITY) == (cmd_word.code == CMD_SETTINGS);
	endproperty
	a_kind: assert property (p_kind) else $error("settings code decoded wrongly");
	property p_cmd_rise; $rose(cmd_valid) |-> $past(cs_n, 3) && !$past(cs_n, 8); endproperty
	a_cmd_rise: assert property (p_cmd_rise) else $error("command applied off select rise");
	property p_int_clr; $fell(int_oe) |-> $past(cs_n, 3) && !$past(cs_n, 6); endproperty
	a_int_clr: assert property (p_int_clr) else $error("interrupt cleared off select rise");
	property p_so_hold; $stable(sclk) [*6] ##0 (so_oe && $past(so_oe)) |-> $stable(so); endproperty
	a_so_hold: assert property (p_so_hold) else $error("so moved without clock edge");
	cover property (cmd_valid && cmd_kind == CK_POLARITY);
	cover property ($fell(int_oe));
	cover property ($fell(in_normal));
endmodule

bind swm_spi_ctrl swm_spi_ctrl_monitor u_mon (.core_clk, .reset_n, .cs_n, .sclk, .so, .so_oe,
	.int_oe, .wake_oe, .logic_supply_ok, .sleep_request, .in_normal, .polarity_bits,
	.cmd_valid, .cmd_kind, .cmd_word);
